// *** bench/cpu_bus_model.sv ***
// cpu-side model: one-cycle data-memory requests and artifact reports
`timescale 1ns/10ps
module cpu_bus_model (
    // clock and answer
    input wire logic clk,
    input wire logic [7:0] rdata,
    input wire logic rvalid,
    // requests
    output logic rd,
    output logic wr,
    output logic stack,
    output logic [7:0] addr,
    output logic [7:0] wdata,
    output logic evt,
    output logic [7:0] ptr
);
    initial begin
        {rd, wr, stack, evt, addr, wdata} = '0;
        ptr = 8'h80;
    end
    task automatic acc(input logic op, input logic stk, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
        @(negedge clk);
        rd = op;
        wr = !op;
        stack = stk;
        addr = a;
        wdata = (a == nvm_pkg::NVM_CFG_ADDR) ? {4'h0, d[3:0]} : d;
        @(negedge clk);
        {rd, wr, stack} = '0;
        addr = ~a;
        wdata = ~wdata;
        q = (op && rvalid) ? rdata : 'x;
    endtask
    task automatic artifact(input logic [7:0] p);
        @(negedge clk);
        evt = 1'b1;
        ptr = p;
        @(negedge clk);
        evt = 1'b0;
        ptr = 8'h80;
    endtask
endmodule

// *** bench/nvm_access_ctrl_monitor.sv ***
// checker: port-level assertions for the segmented data memory controller
`timescale 1ns/10ps
module nvm_access_ctrl_monitor #(parameter int PROG_CYCLES = 8) (
    // clock and reset
    input wire logic CLK,
    input wire logic RESET_N,
    // watched ports
    input wire logic ACC_RD,
    input wire logic ACC_WR,
    input wire logic ACC_STACK,
    input wire logic [7:0] ACC_ADDR,
    input wire logic [7:0] ACC_WDATA,
    input wire logic [7:0] ACC_RDATA,
    input wire logic ACC_RVALID,
    input wire logic GLOBAL_IRQ_ENABLE,
    input wire logic NVM_IRQ,
    input wire logic [7:0] SEGMENT,
    input wire logic [7:0] STACK_POINTER,
    input wire logic NVM_WRITE_BUSY
);
    localparam int BUSY_MIN = PROG_CYCLES;
    localparam int BUSY_MAX = PROG_CYCLES + 2;
    wire logic arr = !ACC_ADDR[7] && !ACC_STACK && SEGMENT == 8'h01;
    default clocking @(posedge CLK); endclocking
    default disable iff (!RESET_N);
    sequence s_start; ACC_WR && arr; endsequence
    sequence s_hold; NVM_WRITE_BUSY[*8]; endsequence
    a_rvalid_after_read: assert property (ACC_RD |=> ACC_RVALID)
        else $error("read not answered");
    a_rvalid_has_cause: assert property (ACC_RVALID |-> $past(ACC_RD))
        else $error("stray read valid");
    a_busy_at_start: assert property (s_start |-> NVM_WRITE_BUSY)
        else $error("busy not raised at write");
    a_busy_holds: assert property ($rose(NVM_WRITE_BUSY) |=> s_hold)
        else $error("busy dropped early");
    a_busy_ends: assert property ($rose(NVM_WRITE_BUSY) |-> ##[BUSY_MIN:BUSY_MAX] !NVM_WRITE_BUSY)
        else $error("busy did not end in time");
    a_seg_write: assert property (ACC_WR && ACC_ADDR == 8'hFF |=> SEGMENT == $past(ACC_WDATA))
        else $error("segment not written");
    a_read_while_busy: assert property (ACC_RD && arr && NVM_WRITE_BUSY |=> ACC_RDATA == 8'h00)
        else $error("blocked read returned data");
    a_irq_needs_gie: assert property (!GLOBAL_IRQ_ENABLE |-> !NVM_IRQ)
        else $error("irq without global enable");
    a_reset_values: assert property (disable iff (1'b0) !RESET_N |=> SEGMENT == 8'h00 && STACK_POINTER == 8'h6F)
        else $error("reset values wrong");
endmodule
bind nvm_access_ctrl nvm_access_ctrl_monitor #(.PROG_CYCLES(PROG_CYCLES)) u_mon (.CLK, .RESET_N, .ACC_RD, .ACC_WR,
    .ACC_STACK, .ACC_ADDR, .ACC_WDATA, .ACC_RDATA, .ACC_RVALID, .GLOBAL_IRQ_ENABLE, .NVM_IRQ, .SEGMENT,
    .STACK_POINTER, .NVM_WRITE_BUSY);

// *** bench/nvm_access_ctrl_tb.sv ***
// testbench for the segmented data memory controller
`timescale 1ns/10ps
module nvm_access_ctrl_tb;
    localparam int PROG = 40;
    localparam logic [7:0] CFG = nvm_pkg::NVM_CFG_ADDR;
    localparam logic [7:0] SEG = nvm_pkg::SEG_SELECT_ADDR;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic global_irq_enable = 1'b0;
    logic rd, wr, stk, art, rvalid, irq, busy;
    logic [7:0] addr, wdata, rdata, ptr, seg, sp, q, d, a;
    logic [15:0] rnd = 16'hEDDD;
    logic [7:0] cv [4] = '{8'h01, 8'h09, 8'h05, 8'h08};
    int n_mismatch = 0;
    int n_checks = 0;
    nvm_access_ctrl #(.PROG_CYCLES(PROG)) i_nvm_access_ctrl (.CLK(clk), .RESET_N(rst_n), .ACC_RD(rd), .ACC_WR(wr),
        .ACC_STACK(stk), .ACC_ADDR(addr), .ACC_WDATA(wdata), .ACC_RDATA(rdata), .ACC_RVALID(rvalid),
        .ARTIFACT_EVENT(art), .INDEX_PTR(ptr), .GLOBAL_IRQ_ENABLE(global_irq_enable), .NVM_IRQ(irq), .SEGMENT(seg),
        .STACK_POINTER(sp), .NVM_WRITE_BUSY(busy));
    cpu_bus_model u_cpu (.clk(clk), .rdata(rdata), .rvalid(rvalid), .rd(rd), .wr(wr), .stack(stk), .addr(addr),
        .wdata(wdata), .evt(art), .ptr(ptr));
    initial begin
        forever #12.5 clk = ~clk;
    end
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    function automatic logic [7:0] ram_exp(input logic [7:0] x, input logic [7:0] v);
        return (x[7:4] == 4'h7) ? 8'h00 : v;
    endfunction
    function automatic logic irq_exp(input logic [7:0] c, input logic g);
        return g & c[0] & (c[3] | c[2]);
    endfunction
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        n_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr8(input logic [7:0] x, input logic [7:0] v);
        u_cpu.acc(1'b0, 1'b0, x, v, q);
    endtask
    task automatic rd8(input logic [7:0] x);
        u_cpu.acc(1'b1, 1'b0, x, 8'h00, d);
    endtask
    task automatic wait_idle;
        for (int i = 0; i < 100 && busy !== 1'b0; i++) @(negedge clk);
    endtask
    task automatic conclude;
        if (n_mismatch == 0 && n_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        #(25 * 3000);
        n_mismatch++;
        conclude();
    end
    initial begin
        repeat (8) @(negedge clk);
        rst_n = 1'b1;
        chk("segment", 8'h00, seg);
        chk("stack_pointer", 8'h6F, sp);
        rd8(CFG);
        chk("config", 8'h00, d);
        for (int i = 0; i < 6; i++) begin
            rnd = lfsr(rnd);
            a = (i == 5) ? 8'h72 : (i == 4) ? 8'hF3 : {2'b00, rnd[13:8]};
            wr8(a, rnd[7:0]);
            rd8(a);
            chk("ram", ram_exp(a, rnd[7:0]), d);
        end
        wr8(SEG, 8'h01);
        rd8(SEG);
        chk("segment_read", 8'h01, d);
        u_cpu.acc(1'b0, 1'b1, 8'h05, 8'h5A, q);
        chk("stack_busy", 8'h00, {7'h0, busy});
        wr8(8'h7F, rnd[7:0]);
        chk("busy", 8'h01, {7'h0, busy});
        rd8(8'h7F);
        chk("array_blocked", 8'h00, d);
        rd8(CFG);
        chk("config_busy", 8'h06, d);
        wr8(CFG, 8'h00);
        rd8(CFG);
        chk("config_ro", 8'h02, d);
        wait_idle();
        rd8(CFG);
        chk("config_done", 8'h08, d);
        rd8(8'h7F);
        chk("array", rnd[7:0], d);
        wr8(SEG, 8'h00);
        rd8(8'h05);
        chk("stack_ram", 8'h5A, d);
        for (int i = 0; i < 8; i++) begin
            global_irq_enable = i[2];
            wr8(CFG, cv[i % 4]);
            chk("irq", {7'h0, irq_exp(cv[i % 4], global_irq_enable)}, {7'h0, irq});
        end
        wr8(CFG, 8'h00);
        wr8(SEG, 8'h01);
        u_cpu.artifact(8'h80);
        rd8(CFG);
        chk("artifact_high", 8'h00, d);
        u_cpu.artifact(8'h7F);
        rd8(CFG);
        chk("artifact_low", 8'h04, d);
        wr8(8'h10, 8'hA5);
        rst_n = 1'b0;
        repeat (2) @(negedge clk);
        rst_n = 1'b1;
        chk("busy_reset", 8'h01, {7'h0, busy});
        rd8(CFG);
        chk("config_reset", 8'h02, d);
        wait_idle();
        wr8(SEG, 8'h01);
        rd8(8'h10);
        chk("array_reset", 8'hA5, d);
        conclude();
    end
endmodule

// *** logic/nvm_access_ctrl.sv ***
// top: segment-extended data memory with nonvolatile segment 1 and its config/status register
`timescale 1ns/10ps
module nvm_access_ctrl #(
    parameter int PROG_CYCLES = nvm_pkg::PROG_CYCLES
) (
    // clock and reset
    input wire logic CLK,
    input wire logic RESET_N,
    // cpu data access, one cycle per request
    input wire logic ACC_RD,
    input wire logic ACC_WR,
    input wire logic ACC_STACK,
    input wire logic [7:0] ACC_ADDR,
    input wire logic [7:0] ACC_WDATA,
    output logic [7:0] ACC_RDATA,
    output logic ACC_RVALID,
    // cpu artifact report: listed opcode or skip while segment selected
    input wire logic ARTIFACT_EVENT,
    input wire logic [7:0] INDEX_PTR,
    // interrupt
    input wire logic GLOBAL_IRQ_ENABLE,
    output logic NVM_IRQ,
    // status
    output logic [7:0] SEGMENT,
    output logic [7:0] STACK_POINTER,
    output logic NVM_WRITE_BUSY
);
    typedef struct packed {
        logic [7:0] seg;
        logic [7:0] sp;
        logic irq_en;
        logic illegal;
        logic done_pend;
        logic [3:0] cfg_hi;
        logic [7:0] rdata;
        logic rvalid;
        logic [7:0] wr_data;
        logic [6:0] wr_addr;
    } state_type;

    state_type st_ff;
    state_type nxt_st;
    logic [7:0] nvm_mem [0:nvm_pkg::NVM_BYTES-1];
    logic [7:0] low_ram [0:nvm_pkg::LOW_RAM_BYTES-1];
    logic [7:0] reg_ram [0:nvm_pkg::REG_RAM_BYTES-1];
    logic [15:0] ext_addr;
    logic [7:0] eff_seg;
    logic is_nvm;
    logic is_low;
    logic is_reg;
    logic is_seg;
    logic is_sp;
    logic is_cfg;
    logic any_acc;
    logic nvm_ok_wr;
    logic [7:0] cfg_view;
    logic [7:0] rd_mux;

    nvm_prog_if prog ();

    nvm_prog_timer #(
        .CYCLES(PROG_CYCLES)
    ) u_timer (
        .clk(CLK),
        .reset_n(RESET_N),
        .prog(prog)
    );

    assign any_acc = ACC_RD | ACC_WR;
    assign eff_seg = ACC_STACK ? 8'h00 : st_ff.seg;

    // address extension
    always_comb begin
        if (ACC_ADDR[7]) begin
            ext_addr = {8'h00, ACC_ADDR};
        end else begin
            ext_addr = {eff_seg, 1'b0, ACC_ADDR[6:0]};
        end
    end

    always_comb begin
        is_nvm = 1'b0;
        is_low = 1'b0;
        is_reg = 1'b0;
        is_seg = 1'b0;
        is_sp = 1'b0;
        is_cfg = 1'b0;
        if (ext_addr == {8'h00, nvm_pkg::SEG_SELECT_ADDR}) begin
            is_seg = 1'b1;
        end else if (ext_addr == {8'h00, nvm_pkg::SP_ADDR}) begin
            is_sp = 1'b1;
        end else if (ext_addr == {8'h00, nvm_pkg::NVM_CFG_ADDR}) begin
            is_cfg = 1'b1;
        end else if (ext_addr[15:8] == nvm_pkg::NVM_SEGMENT && !ext_addr[7]) begin
            is_nvm = 1'b1;
        end else if (ext_addr <= nvm_pkg::RAM_LOW_TOP) begin
            is_low = 1'b1;
        end else if (ext_addr >= nvm_pkg::REG_BASE) begin
            is_reg = 1'b1;
        end
    end

    assign cfg_view = {st_ff.cfg_hi, st_ff.done_pend, st_ff.illegal, prog.busy, st_ff.irq_en};

    // write to the array only when idle, otherwise discarded
    assign nvm_ok_wr = ACC_WR & is_nvm & ~prog.busy;
    assign prog.start = nvm_ok_wr;

    always_comb begin
        rd_mux = 8'h00;
        if (is_seg) begin
            rd_mux = st_ff.seg;
        end else if (is_sp) begin
            rd_mux = st_ff.sp;
        end else if (is_cfg) begin
            rd_mux = cfg_view;
        end else if (is_nvm) begin
            rd_mux = prog.busy ? 8'h00 : nvm_mem[ext_addr[6:0]];
        end else if (is_low) begin
            rd_mux = low_ram[ext_addr[6:0]];
        end else if (is_reg) begin
            rd_mux = reg_ram[ext_addr[3:0]];
        end
    end

    always_comb begin
        nxt_st = st_ff;
        nxt_st.rvalid = ACC_RD;
        if (ACC_RD) begin
            nxt_st.rdata = rd_mux;
        end
        if (ACC_WR && is_seg) begin
            nxt_st.seg = ACC_WDATA;
        end
        if (ACC_WR && is_sp) begin
            nxt_st.sp = ACC_WDATA;
        end
        if (ACC_WR && is_cfg) begin
            nxt_st.irq_en = ACC_WDATA[nvm_pkg::CFG_IRQ_EN_BIT];
            nxt_st.illegal = ACC_WDATA[nvm_pkg::CFG_ILLEGAL_BIT];
            nxt_st.done_pend = ACC_WDATA[nvm_pkg::CFG_DONE_BIT];
            nxt_st.cfg_hi = ACC_WDATA[7:4];
            // busy bit in the write data is dropped
        end
        if (nvm_ok_wr) begin
            nxt_st.wr_addr = ext_addr[6:0];
            nxt_st.wr_data = ACC_WDATA;
        end
        // hardware sets win over software clears
        if (any_acc && is_nvm && prog.busy) begin
            nxt_st.illegal = 1'b1;
        end
        if (ARTIFACT_EVENT && st_ff.seg == nvm_pkg::NVM_SEGMENT && !INDEX_PTR[7]) begin
            nxt_st.illegal = 1'b1;
        end
        if (prog.done) begin
            nxt_st.done_pend = 1'b1;
        end
    end

    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            st_ff.seg <= nvm_pkg::SEG_RESET;
            st_ff.sp <= nvm_pkg::SP_RESET;
            st_ff.irq_en <= nvm_pkg::CFG_RESET[nvm_pkg::CFG_IRQ_EN_BIT];
            st_ff.illegal <= nvm_pkg::CFG_RESET[nvm_pkg::CFG_ILLEGAL_BIT];
            st_ff.done_pend <= nvm_pkg::CFG_RESET[nvm_pkg::CFG_DONE_BIT];
            st_ff.cfg_hi <= nvm_pkg::CFG_RESET[7:4];
            st_ff.rdata <= 8'h00;
            st_ff.rvalid <= 1'b0;
            // pending write data is kept so a running cycle still lands
            st_ff.wr_data <= st_ff.wr_data;
            st_ff.wr_addr <= st_ff.wr_addr;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // storage arrays; array byte lands when the programming cycle completes
    always_ff @(posedge CLK) begin
        if (prog.done) begin
            nvm_mem[st_ff.wr_addr] <= st_ff.wr_data;
        end
        if (RESET_N && ACC_WR && is_low) begin
            low_ram[ext_addr[6:0]] <= ACC_WDATA;
        end
        if (RESET_N && ACC_WR && is_reg) begin
            reg_ram[ext_addr[3:0]] <= ACC_WDATA;
        end
    end

    assign NVM_IRQ = GLOBAL_IRQ_ENABLE & st_ff.irq_en & (st_ff.done_pend | st_ff.illegal);
    assign ACC_RDATA = st_ff.rdata;
    assign ACC_RVALID = st_ff.rvalid;
    assign SEGMENT = st_ff.seg;
    assign STACK_POINTER = st_ff.sp;
    assign NVM_WRITE_BUSY = prog.busy | prog.start;
endmodule

// *** logic/nvm_pkg.sv ***
// package: data memory map, config/status fields, reset values and timing counts
package nvm_pkg;
    localparam logic [7:0] SEG_SELECT_ADDR = 8'hFF;
    localparam logic [7:0] SP_ADDR = 8'hFD;
    localparam logic [7:0] NVM_CFG_ADDR = 8'hE1;
    localparam logic [7:0] NVM_SEGMENT = 8'h01;
    localparam logic [7:0] SP_RESET = 8'h6F;
    localparam logic [7:0] SEG_RESET = 8'h00;
    localparam logic [15:0] RAM_LOW_TOP = 16'h006F;
    localparam logic [15:0] REG_BASE = 16'h00F0;
    localparam int NVM_BYTES = 128;
    localparam int LOW_RAM_BYTES = 112;
    localparam int REG_RAM_BYTES = 16;
    // config/status bit positions
    localparam int CFG_IRQ_EN_BIT = 0;
    localparam int CFG_BUSY_BIT = 1;
    localparam int CFG_ILLEGAL_BIT = 2;
    localparam int CFG_DONE_BIT = 3;
    localparam logic [7:0] CFG_RESET = 8'h00;
    // programming time in instruction cycles
    localparam int CLK_MHZ = 40;
    localparam int PROG_TIME_US = 10000;
    localparam int PROG_CYCLES = PROG_TIME_US * CLK_MHZ;
    localparam int PROG_CNT_W = 20;
endpackage

// *** logic/nvm_prog_if.sv ***
// interface: program start handshake between access decoder and programming timer
`timescale 1ns/10ps
interface nvm_prog_if;
    logic start;
    logic busy;
    logic done;
    modport ctrl (output start, input busy, input done);
    modport timer (input start, output busy, output done);
endinterface

// *** logic/nvm_prog_timer.sv ***
// programming-cycle timer: runs to completion, ignores reset while busy
`timescale 1ns/10ps
module nvm_prog_timer #(
    parameter int CYCLES = nvm_pkg::PROG_CYCLES
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // handshake
    nvm_prog_if.timer prog
);
    typedef struct packed {
        logic busy;
        logic done;
        logic [nvm_pkg::PROG_CNT_W-1:0] cnt;
    } state_type;

    state_type st_ff;
    state_type nxt_st;

    always_comb begin
        nxt_st = st_ff;
        nxt_st.done = 1'b0;
        if (st_ff.busy) begin
            if (st_ff.cnt == nvm_pkg::PROG_CNT_W'(CYCLES - 1)) begin
                nxt_st.busy = 1'b0;
                nxt_st.done = 1'b1;
                nxt_st.cnt = '0;
            end else begin
                nxt_st.cnt = st_ff.cnt + 1'b1;
            end
        end else if (prog.start) begin
            nxt_st.busy = 1'b1;
            nxt_st.cnt = '0;
        end
    end

    always_ff @(posedge clk) begin
        // a running cycle is never aborted by reset
        if (!reset_n) begin
            if (st_ff.busy) begin
                st_ff <= nxt_st;
            end else begin
                st_ff <= '0;
            end
        end else begin
            st_ff <= nxt_st;
        end
    end

    // registered busy only, so the start decision cannot loop back on itself
    assign prog.busy = st_ff.busy;
    assign prog.done = st_ff.done;
endmodule
